/* File: dv/rrb_frame_src.sv */
// Far-side model: a remote port sending one received frame per call.
// Assumes the bench calls send from its main sequence, after reset.
`timescale 1ns/10ps
module rrb_frame_src (
  input  wire         clk,
  output logic        frm_start,
  output logic        err_valid,
  output logic [7:0]  err_reason,
  output logic [7:0]  err_vendor,
  output logic        frm_end,
  output logic [1:0]  frm_class,
  output logic        frm_link_ctl,
  output logic        frm_is_ack,
  output logic        frm_is_reject,
  output logic        frm_xchg_valid,
  output logic        frm_xid_assign,
  output logic        frm_dst_fabric,
  output logic [23:0] frm_d_id,
  output logic [23:0] frm_s_id,
  output logic [23:0] frm_f_ctl,
  output logic [7:0]  frm_seq_id,
  output logic [15:0] frm_seq_cnt
);
  localparam logic [95:0] HDR = {24'h0a0b0c, 24'h010203, 24'h812345, 8'h33, 16'h0102};
  initial begin
    {frm_start, err_valid, frm_end, frm_class, frm_link_ctl, frm_is_ack, frm_is_reject} = '0;
    {frm_xchg_valid, frm_xid_assign, frm_dst_fabric, err_reason, err_vendor} = '0;
    {frm_d_id, frm_s_id, frm_f_ctl, frm_seq_id, frm_seq_cnt} = ~HDR;
  end
  // Second error of zero means a single-error frame
  task send(input logic [7:0] r1, r2, v, input logic [1:0] c, input logic lc, ack, rej, xv,
            input logic xa = 1'b0, input logic df = 1'b0);
    @(posedge clk);
    frm_start <= 1'b1;
    @(posedge clk);
    frm_start <= 1'b0;
    err_valid <= 1'b1;
    err_reason <= r1;
    err_vendor <= v;
    @(posedge clk);
    err_valid <= (r2 != 8'h00);
    err_reason <= r2;
    @(posedge clk);
    err_valid <= 1'b0;
    err_reason <= ~r2;
    frm_end <= 1'b1;
    {frm_class, frm_link_ctl, frm_is_ack, frm_is_reject, frm_xchg_valid} <= {c, lc, ack, rej, xv};
    {frm_xid_assign, frm_dst_fabric} <= {xa, df};
    {frm_d_id, frm_s_id, frm_f_ctl, frm_seq_id, frm_seq_cnt} <= HDR;
    @(posedge clk);
    frm_end <= 1'b0;
    // Header is only valid with frm_end; scramble it afterwards
    {frm_d_id, frm_s_id, frm_f_ctl, frm_seq_id, frm_seq_cnt} <= ~HDR;
  endtask
endmodule

/* File: dv/rrb_reject_builder_assertions.sv */
// Checker for the reject builder; sees only the top module's ports.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/10ps
module rrb_checker (
  input logic        clk,
  input logic        rst_n,
  input logic        is_fabric,
  input logic        frm_end,
  input logic [1:0]  frm_class,
  input logic        frm_link_ctl,
  input logic        frm_is_reject,
  input logic [23:0] frm_d_id,
  input logic [23:0] frm_s_id,
  input logic [23:0] frm_f_ctl,
  input logic        rjt_valid,
  input logic        rjt_eof_term,
  input logic [23:0] rjt_d_id,
  input logic [23:0] rjt_s_id,
  input logic [23:0] rjt_f_ctl,
  input logic [31:0] rjt_param,
  input logic        abort_seq,
  input logic        frm_drop
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_class3_drop: assert property (frm_end && frm_class == 2'h3 |=> !rjt_valid) else $error("class 3 rejected");
  chk_reject_drop: assert property (frm_end && frm_is_reject |=> !rjt_valid) else $error("reject answered");
  chk_id_swap: assert property (rjt_valid |-> rjt_d_id == $past(frm_s_id) && rjt_s_id == $past(frm_d_id))
    else $error("ids not swapped");
  chk_ctx_flip: assert property (rjt_valid |-> rjt_f_ctl == ($past(frm_f_ctl) ^ 24'hc00000)) else $error("f_ctl");
  chk_rsv_zero: assert property (rjt_valid |-> rjt_param[15:8] == 8'h00) else $error("reserved byte");
  chk_action_ok: assert property (rjt_valid |-> rjt_param[31:24] inside {8'h01, 8'h02}) else $error("action");
  chk_reason_legal: assert property (rjt_valid |-> !(rjt_param[23:16] inside {8'h00, 8'h19, 8'h1b}))
    else $error("reason");
  chk_vendor_zero: assert property (rjt_valid && rjt_param[23:16] != 8'hff |-> rjt_param[7:0] == 8'h00)
    else $error("vendor byte");
  chk_one_result: assert property ($onehot0({rjt_valid, abort_seq, frm_drop})) else $error("two results");
  chk_result_time: assert property (rjt_valid || abort_seq || frm_drop |-> $past(frm_end)) else $error("late");
  chk_port_lc: assert property (frm_end && !is_fabric && frm_link_ctl |=>
    !rjt_valid || rjt_param[31:16] == 16'h0214) else $error("port lc reject");
  chk_fab_lc: assert property (frm_end && is_fabric && frm_link_ctl |=>
    !rjt_valid || rjt_param[23:16] inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h16}) else $error("fabric lc");
  chk_lc_eofn: assert property (frm_end && frm_link_ctl |=> !rjt_valid || !rjt_eof_term) else $error("lc eof");
endmodule
bind rrb_reject_builder rrb_checker i_chk (.*);

/* File: dv/testbench.sv */
// Self-checking bench for the reject builder, frames from rrb_frame_src.
// Assumes the design and checker are compiled first.
`timescale 1ns/10ps
module testbench;
  logic        clk, rst_n, is_fabric, frm_start, err_valid, frm_end, frm_link_ctl, frm_is_ack, frm_is_reject;
  logic        frm_xchg_valid, frm_xid_assign, frm_dst_fabric, rjt_valid, rjt_fabric, rjt_eof_term, abort_seq, frm_drop;
  logic [7:0]  err_reason, err_vendor, frm_seq_id, rjt_seq_id;
  logic [1:0]  frm_class, outcome;
  logic [23:0] frm_d_id, frm_s_id, frm_f_ctl, rjt_d_id, rjt_s_id, rjt_f_ctl;
  logic [15:0] frm_seq_cnt, rjt_seq_cnt;
  logic [31:0] rjt_param;
  int          failures, num_checks;
  rrb_reject_builder i_dut (.*);
  rrb_frame_src i_src (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task cmp(input string n, input logic [31:0] e, s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task res(input logic [1:0] k, input logic [31:0] p);
    #1;
    cmp("outcome", {30'h0, k}, {30'h0, outcome});
    cmp("pulses", {29'h0, k == 2'h1, k == 2'h2, k == 2'h3}, {29'h0, rjt_valid, abort_seq, frm_drop});
    if (k == 2'h1) cmp("param", p, rjt_param);
  endtask
  task mode(input logic f);
    @(posedge clk);
    is_fabric <= f;
  endtask
  task s_walk;
    mode(1'b0);
    i_src.send(8'h01, 8'h07, 8'h00, 2'h2, 0, 0, 0, 1);
    res(2'h1, 32'h01010000);
    cmp("d_id", {8'h0, 24'h010203}, {8'h0, rjt_d_id});
    cmp("s_id", {8'h0, 24'h0a0b0c}, {8'h0, rjt_s_id});
    cmp("f_ctl", {8'h0, 24'h412345}, {8'h0, rjt_f_ctl});
    cmp("seq", {8'h33, 16'h0102}, {rjt_seq_id, rjt_seq_cnt});
    cmp("eof", 32'h0, {31'h0, rjt_eof_term});
    cmp("fabric", 32'h0, {31'h0, rjt_fabric});
  endtask
  task s_port;
    mode(1'b0);
    i_src.send(8'h05, 8'h00, 8'h00, 2'h3, 0, 0, 0, 1);
    res(2'h3, 32'h0);
    i_src.send(8'h02, 8'h00, 8'h00, 2'h2, 0, 0, 1, 1);
    res(2'h3, 32'h0);
    i_src.send(8'h19, 8'h00, 8'h00, 2'h2, 0, 0, 0, 1);
    res(2'h3, 32'h0);
    i_src.send(8'hff, 8'h00, 8'h5a, 2'h2, 0, 0, 0, 1);
    res(2'h1, 32'h01ff005a);
    i_src.send(8'h0b, 8'h00, 8'h00, 2'h2, 0, 0, 0, 1);
    res(2'h1, 32'h020b0000);
    i_src.send(8'h01, 8'h00, 8'h00, 2'h2, 0, 0, 0, 1, 1);
    res(2'h1, 32'h01010000);
    cmp("eof", 32'h1, {31'h0, rjt_eof_term});
    i_src.send(8'h14, 8'h00, 8'h00, 2'h2, 1, 1, 0, 1, 1);
    res(2'h1, 32'h02140000);
    cmp("eof", 32'h0, {31'h0, rjt_eof_term});
    i_src.send(8'h0b, 8'h00, 8'h00, 2'h2, 1, 0, 0, 1);
    res(2'h2, 32'h0);
    i_src.send(8'h0b, 8'h00, 8'h00, 2'h2, 1, 0, 0, 0);
    res(2'h3, 32'h0);
  endtask
  task s_fabric;
    logic [7:0] codes [6];
    codes = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h16};
    mode(1'b1);
    foreach (codes[i]) begin
      i_src.send(codes[i], 8'h00, 8'h00, 2'h2, 1, 0, 0, 1);
      res(2'h1, {8'h01, codes[i], 16'h0});
      cmp("fabric", 32'h1, {31'h0, rjt_fabric});
    end
    i_src.send(8'h07, 8'h00, 8'h00, 2'h2, 1, 0, 0, 1);
    res(2'h3, 32'h0);
    i_src.send(8'h07, 8'h00, 8'h00, 2'h2, 0, 0, 0, 1, 0, 0);
    res(2'h3, 32'h0);
    i_src.send(8'h07, 8'h00, 8'h00, 2'h2, 0, 0, 0, 1, 0, 1);
    res(2'h1, 32'h02070000);
    i_src.send(8'h1a, 8'h00, 8'h00, 2'h2, 0, 0, 0, 1);
    res(2'h1, 32'h011a0000);
  endtask
  task give_verdict;
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    is_fabric = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    s_walk;
    s_port;
    s_fabric;
    give_verdict;
  end
  // About 100 cycles of traffic; far longer means a hang
  initial begin
    #5000;
    failures++;
    give_verdict;
  end
endmodule

/* File: inc/rrb_defs.vh */
// Constants for the reject response builder: reason and action
// codes, Parameter word layout, F_CTL context bits, class codes.
// Assumes inclusion by bare name from the design files.
`ifndef RRB_DEFS_VH
`define RRB_DEFS_VH

// ----------------------------------------
// Parameter word layout
// ----------------------------------------
`define RRB_PRM_ACT_HI    31
`define RRB_PRM_ACT_LO    24
`define RRB_PRM_RSN_HI    23
`define RRB_PRM_RSN_LO    16
`define RRB_PRM_RSV_HI    15
`define RRB_PRM_RSV_LO    8
`define RRB_PRM_VND_HI    7
`define RRB_PRM_VND_LO    0
`define RRB_PRM_RSV_VAL   8'h00
`define RRB_VND_NONE      8'h00

// ----------------------------------------
// F_CTL context bits
// ----------------------------------------
`define RRB_FCTL_XCHG_CTX 23
`define RRB_FCTL_SEQ_CTX  22

// ----------------------------------------
// Action codes
// ----------------------------------------
`define RRB_ACT_RETRY     8'h01
`define RRB_ACT_NORETRY   8'h02

// ----------------------------------------
// Class codes
// ----------------------------------------
`define RRB_CLASS_3       2'h3

// ----------------------------------------
// Reason codes
// ----------------------------------------
`define RRB_RSN_BAD_DID   8'h01
`define RRB_RSN_BAD_SID   8'h02
`define RRB_RSN_TMP_UNAV  8'h03
`define RRB_RSN_PRM_UNAV  8'h04
`define RRB_RSN_CLASS     8'h05
`define RRB_RSN_DELIM     8'h06
`define RRB_RSN_TYPE      8'h07
`define RRB_RSN_BAD_LC    8'h08
`define RRB_RSN_BAD_RCTL  8'h09
`define RRB_RSN_BAD_FCTL  8'h0a
`define RRB_RSN_BAD_OXID  8'h0b
`define RRB_RSN_BAD_RXID  8'h0c
`define RRB_RSN_BAD_SQID  8'h0d
`define RRB_RSN_BAD_DFCTL 8'h0e
`define RRB_RSN_BAD_SQCNT 8'h0f
`define RRB_RSN_BAD_PARM  8'h10
`define RRB_RSN_XCHG_ERR  8'h11
`define RRB_RSN_PROTO     8'h12
`define RRB_RSN_LENGTH    8'h13
`define RRB_RSN_UNEXP_ACK 8'h14
`define RRB_RSN_FLOGI_CLS 8'h15
`define RRB_RSN_LOGIN     8'h16
`define RRB_RSN_EXCESS    8'h17
`define RRB_RSN_NO_XCHG   8'h18
`define RRB_RSN_NO_PATH   8'h1a
`define RRB_RSN_VENDOR    8'hff

// ----------------------------------------
// Reason attribute bits
// ----------------------------------------
`define RRB_ATTR_FAB      2
`define RRB_ATTR_PORT     1
`define RRB_ATTR_RTRY     0

// ----------------------------------------
// Outcome codes
// ----------------------------------------
`define RRB_OUT_NONE      2'h0
`define RRB_OUT_REJECT    2'h1
`define RRB_OUT_ABORT     2'h2
`define RRB_OUT_DROP      2'h3

`endif

/* File: logic/rrb_reject_builder.v */
// Reject response builder: decides per received frame whether an
// error is answered by a Reject, triggers Abort Sequence, or is
// dropped, and builds the Reject header and Parameter word.
// Assumes a frame checker on the same clock that frames each frame
// with start/end pulses and reports errors as reason-code pulses.
`timescale 1ns/10ps
`include "rrb_defs.vh"

// Overview of operation
// [R1] Reject denies delivery; four-byte code in Parameter
// [R2] Class 2 Data error yields Reject with reason
// [R3] Fabric rejects Link_Control for six causes only
// [R4] Port rejects Link_Control only for unexpected ACK
// [R5] Other Link_Control error, valid Exchange: abort
// [R6] Link_Control error, invalid Exchange: drop silently
// [R7] Class 3 rejectable frames are dropped
// [R8] Never reject a Reject; drop it
// [R9] Swap S_ID and D_ID in Reject header
// [R10] Complement Exchange and Sequence Context bits
// [R11] Copy SEQ_ID and SEQ_CNT unchanged
// [R12] Payload of rejected frame is discarded
// [R13] Parameter: action, reason, reserved, vendor bytes
// [R14] First detected error is the reported one
// [R15] Action 01h retryable, source-limited use
// [R16] Action 02h only where sender is destination
// [R17] Reason 01h-05h legal sources, retryable
// [R18] Reasons 06h-14h legal sources, non-retryable
// [R19] Reasons 15h-18h legal sources, retryable
// [R20] 1Ah Fabric retryable; 19h, 1Bh never sent
// [R21] FFh vendor reject, detail in bits 7-0
// [R22] EOFt ends Sequence; EOFn asks receiver abort
// [R23] Reserved byte zero; vendor byte zero normally
module rrb_reject_builder (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        is_fabric,
  input  wire        frm_start,
  input  wire        err_valid,
  input  wire [7:0]  err_reason,
  input  wire [7:0]  err_vendor,
  input  wire        frm_end,
  input  wire [1:0]  frm_class,
  input  wire        frm_link_ctl,
  input  wire        frm_is_ack,
  input  wire        frm_is_reject,
  input  wire        frm_xchg_valid,
  input  wire        frm_xid_assign,
  input  wire        frm_dst_fabric,
  input  wire [23:0] frm_d_id,
  input  wire [23:0] frm_s_id,
  input  wire [23:0] frm_f_ctl,
  input  wire [7:0]  frm_seq_id,
  input  wire [15:0] frm_seq_cnt,
  output reg         rjt_valid,
  output reg         rjt_fabric,
  output reg         rjt_eof_term,
  output reg  [23:0] rjt_d_id,
  output reg  [23:0] rjt_s_id,
  output reg  [23:0] rjt_f_ctl,
  output reg  [7:0]  rjt_seq_id,
  output reg  [15:0] rjt_seq_cnt,
  output reg  [31:0] rjt_param,
  output reg         abort_seq,
  output reg         frm_drop,
  output reg  [1:0]  outcome
);

  // ----------------------------------------
  // Reason code tables
  // ----------------------------------------
  // One entry per code, so each source and retry limit can be audited
  function [2:0] rsn_attr;
    input [7:0] rsn;
    begin
      case (rsn)
        `RRB_RSN_BAD_DID: begin // R17
          rsn_attr[`RRB_ATTR_FAB]  = 1'b1;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b1;
        end
        `RRB_RSN_BAD_SID: begin // R17
          rsn_attr[`RRB_ATTR_FAB]  = 1'b1;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b1;
        end
        `RRB_RSN_TMP_UNAV: begin // R17
          rsn_attr[`RRB_ATTR_FAB]  = 1'b1;
          rsn_attr[`RRB_ATTR_PORT] = 1'b0;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b1;
        end
        `RRB_RSN_PRM_UNAV: begin // R17
          rsn_attr[`RRB_ATTR_FAB]  = 1'b1;
          rsn_attr[`RRB_ATTR_PORT] = 1'b0;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b1;
        end
        `RRB_RSN_CLASS: begin // R17
          rsn_attr[`RRB_ATTR_FAB]  = 1'b1;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b1;
        end
        `RRB_RSN_DELIM: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b1;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_TYPE: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b1;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_BAD_LC: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_BAD_RCTL: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_BAD_FCTL: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_BAD_OXID: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_BAD_RXID: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_BAD_SQID: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_BAD_DFCTL: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b1;
          rsn_attr[`RRB_ATTR_PORT] = 1'b0;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_BAD_SQCNT: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_BAD_PARM: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_XCHG_ERR: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_PROTO: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_LENGTH: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b1;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_UNEXP_ACK: begin // R18
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
        `RRB_RSN_FLOGI_CLS: begin // R19
          rsn_attr[`RRB_ATTR_FAB]  = 1'b1;
          rsn_attr[`RRB_ATTR_PORT] = 1'b0;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b1;
        end
        `RRB_RSN_LOGIN: begin // R19
          rsn_attr[`RRB_ATTR_FAB]  = 1'b1;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b1;
        end
        `RRB_RSN_EXCESS: begin // R19
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b1;
        end
        `RRB_RSN_NO_XCHG: begin // R19
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b1;
        end
        `RRB_RSN_NO_PATH: begin // R20
          rsn_attr[`RRB_ATTR_FAB]  = 1'b1;
          rsn_attr[`RRB_ATTR_PORT] = 1'b0;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b1;
        end
        `RRB_RSN_VENDOR: begin // R21
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b1;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b1;
        end
        default: begin // R20
          rsn_attr[`RRB_ATTR_FAB]  = 1'b0;
          rsn_attr[`RRB_ATTR_PORT] = 1'b0;
          rsn_attr[`RRB_ATTR_RTRY] = 1'b0;
        end
      endcase
    end
  endfunction

  // Legal for the issuing side; 19h, 1Bh and others never pass
  function rsn_legal;
    input [7:0] rsn;
    input       fab;
    reg   [2:0] attr;
    begin
      attr      = rsn_attr(rsn);
      rsn_legal = fab ? attr[`RRB_ATTR_FAB] : attr[`RRB_ATTR_PORT];
    end
  endfunction

  // Retryable reasons map to action 1, the rest to action 2
  function rsn_retry;
    input [7:0] rsn;
    reg   [2:0] attr;
    begin
      attr      = rsn_attr(rsn);
      rsn_retry = attr[`RRB_ATTR_RTRY];
    end
  endfunction

  // Link_Control causes a Fabric may reject for
  function fab_lc_cause;
    input [7:0] rsn;
    begin
      fab_lc_cause = rsn == `RRB_RSN_CLASS || rsn == `RRB_RSN_BAD_DID ||
                     rsn == `RRB_RSN_BAD_SID || rsn == `RRB_RSN_TMP_UNAV ||
                     rsn == `RRB_RSN_PRM_UNAV || rsn == `RRB_RSN_LOGIN; // R3
    end
  endfunction

  // ----------------------------------------
  // First-error capture
  // ----------------------------------------
  reg        err_seen;
  reg [7:0]  err_rsn;
  reg [7:0]  err_vnd;
  wire       cur_err;
  wire [7:0] cur_rsn;
  wire [7:0] cur_vnd;

  // An error in the end cycle still counts when none came earlier;
  // one kept from between frames dies with the next start
  assign cur_err = (err_seen & ~frm_start) | err_valid;
  assign cur_rsn = (err_seen & ~frm_start) ? err_rsn : err_reason;
  assign cur_vnd = (err_seen & ~frm_start) ? err_vnd : err_vendor;

  always @(posedge clk) begin
    if (!rst_n) begin
      err_seen <= 1'b0;
      err_rsn  <= 8'h00;
      err_vnd  <= 8'h00;
    end else if (frm_start || frm_end) begin
      // A start in the same cycle as an error keeps that error
      err_seen <= frm_start & err_valid;
      err_rsn  <= err_reason;
      err_vnd  <= err_vendor;
    end else if (err_valid && !err_seen) begin
      err_seen <= 1'b1; // R14
      err_rsn  <= err_reason; // R14
      err_vnd  <= err_vendor;
    end
  end

  // ----------------------------------------
  // Decision
  // ----------------------------------------
  reg [1:0] next_outcome;
  reg [7:0] next_action;
  reg       retry;

  always @* begin
    next_outcome = `RRB_OUT_NONE;
    retry        = rsn_retry(cur_rsn);
    next_action  = retry ? `RRB_ACT_RETRY : `RRB_ACT_NORETRY; // R15 R16
    if (frm_end && cur_err) begin
      if (frm_class == `RRB_CLASS_3) begin
        next_outcome = `RRB_OUT_DROP; // R7
      end else if (frm_is_reject) begin
        next_outcome = `RRB_OUT_DROP; // R8
      end else if (!rsn_legal(cur_rsn, is_fabric)) begin
        // No legal code to report, so nothing can be sent
        next_outcome = `RRB_OUT_DROP;
      end else if (frm_link_ctl) begin
        if (is_fabric) begin
          if (fab_lc_cause(cur_rsn))
            next_outcome = `RRB_OUT_REJECT; // R3
          else
            next_outcome = `RRB_OUT_DROP; // R3
        end else if (frm_is_ack && cur_rsn == `RRB_RSN_UNEXP_ACK) begin
          next_outcome = `RRB_OUT_REJECT; // R4
          next_action  = `RRB_ACT_NORETRY; // R4
        end else if (frm_xchg_valid) begin
          next_outcome = `RRB_OUT_ABORT; // R5
        end else begin
          next_outcome = `RRB_OUT_DROP; // R6
        end
      end else if (is_fabric && !retry && !frm_dst_fabric) begin
        // Fabric may only give action 2 as the destination itself
        next_outcome = `RRB_OUT_DROP; // R16
      end else begin
        next_outcome = `RRB_OUT_REJECT; // R2
      end
    end
  end

  // ----------------------------------------
  // Reject frame build
  // ----------------------------------------
  // Header only: no payload port exists, so any Data_Field is lost
  always @(posedge clk) begin
    if (!rst_n) begin
      rjt_valid    <= 1'b0;
      rjt_fabric   <= 1'b0;
      rjt_eof_term <= 1'b0;
      rjt_d_id     <= 24'h000000;
      rjt_s_id     <= 24'h000000;
      rjt_f_ctl    <= 24'h000000;
      rjt_seq_id   <= 8'h00;
      rjt_seq_cnt  <= 16'h0000;
      rjt_param    <= 32'h00000000;
      abort_seq    <= 1'b0;
      frm_drop     <= 1'b0;
      outcome      <= `RRB_OUT_NONE;
    end else begin
      rjt_valid <= (next_outcome == `RRB_OUT_REJECT); // R1 R12
      abort_seq <= (next_outcome == `RRB_OUT_ABORT); // R5
      frm_drop  <= (next_outcome == `RRB_OUT_DROP); // R6 R7 R8
      if (frm_end)
        outcome <= next_outcome;
      if (next_outcome == `RRB_OUT_REJECT) begin
        rjt_fabric <= is_fabric;
        // Terminate only on an X_ID-assigning interlocked frame;
        // the unexpected-ACK reject always uses EOFn
        rjt_eof_term <= frm_xid_assign & ~frm_link_ctl; // R22
        rjt_d_id <= frm_s_id; // R9
        rjt_s_id <= frm_d_id; // R9
        rjt_f_ctl <= frm_f_ctl; // R10
        rjt_f_ctl[`RRB_FCTL_XCHG_CTX] <= ~frm_f_ctl[`RRB_FCTL_XCHG_CTX]; // R10
        rjt_f_ctl[`RRB_FCTL_SEQ_CTX] <= ~frm_f_ctl[`RRB_FCTL_SEQ_CTX]; // R10
        rjt_seq_id  <= frm_seq_id; // R11
        rjt_seq_cnt <= frm_seq_cnt; // R11
        rjt_param[`RRB_PRM_ACT_HI:`RRB_PRM_ACT_LO] <= next_action; // R13
        rjt_param[`RRB_PRM_RSN_HI:`RRB_PRM_RSN_LO] <= cur_rsn; // R13
        rjt_param[`RRB_PRM_RSV_HI:`RRB_PRM_RSV_LO] <= `RRB_PRM_RSV_VAL; // R23
        rjt_param[`RRB_PRM_VND_HI:`RRB_PRM_VND_LO] <=
          (cur_rsn == `RRB_RSN_VENDOR) ? cur_vnd : `RRB_VND_NONE; // R21 R23
      end
    end
  end

endmodule
